// File: hdl/ctr_map.svh
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH
// register offsets
`define CTR_ADDR_SPC      13'h0000
`define CTR_ADDR_RBS      13'h0004
`define CTR_ADDR_TRIG     13'h0005
`define CTR_ADDR_CPC      13'h000A
`define CTR_ADDR_PDC      13'h000B
`define CTR_ADDR_PCD      13'h000C
`define CTR_ADDR_BLD      13'h000D
`define CTR_ADDR_OSC      13'h000E
`define CTR_ADDR_OSL      13'h000F
`define CTR_ADDR_OSB      13'h0010
`define CTR_ADDR_SPARE    13'h0011
`define CTR_ADDR_FBH      13'h0012
`define CTR_ADDR_FBM      13'h0013
`define CTR_ADDR_LAST     13'h0013
// reset values
`define CTR_RST_SPC       8'h18
`define CTR_RST_CPC       8'h80
`define CTR_RST_PDC       8'h30
`define CTR_RST_OSC       8'h70
`define CTR_RST_OSL       8'h80
`define CTR_RST_OSB       8'h80
`define CTR_RST_FBH       8'h80
`define CTR_RST_ZERO      8'h00
// field positions
`define CTR_INS_RW        15
`define CTR_INS_LEN_HI    14
`define CTR_INS_LEN_LO    13
`define CTR_BIT_RBSEL     0
`define CTR_BIT_TRIG      0
`define CTR_BIT_SOFTRST   5
`define CTR_BIT_VCOCAL    7
`define CTR_LEN_STREAM    2'h3
`define CTR_INS_BITS      5'h10
`define CTR_NUM_REGS      20
// autoclear command hold time in mclk cycles
`define CTR_CAL_CYCLES    4'hF
`endif

// File: hdl/ctr_pkg.sv
`default_nettype none
package ctr_pkg;
    // decoded instruction word
    typedef struct packed {
        logic        rd;
        logic [1:0]  len;
        logic [12:0] addr;
    } ctr_instr_t;
    // serial port states, gray on the steps from idle to data
    typedef enum logic [1:0] {
        CTR_IDLE  = 2'b00,
        CTR_INSTR = 2'b01,
        CTR_DATA  = 2'b11
    } ctr_state_t;
    // serial pins after sampling
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdio;
    } ctr_pins_t;
endpackage
`default_nettype wire

// File: hdl/ctr_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for the serial pins
module ctr_sync (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    // raw pins
    input  wire ctr_pkg::ctr_pins_t i_pins,
    // synchronised pins
    output ctr_pkg::ctr_pins_t    o_pins
);
    ctr_pkg::ctr_pins_t meta;   // first stage, read only by second
    // two flops; idle level has chip select high
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta   <= 3'b010;
            o_pins <= 3'b010;
        end else begin
            meta   <= i_pins;
            o_pins <= meta;
        end
    end
endmodule
`default_nettype wire

// File: hdl/ctr_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctr_map.svh"
module ctr_regs (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // serial control port
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_sdio,
    output logic             o_sdio,
    output logic             o_sdio_oe,
    // active control values
    output logic [7:0]       o_pump_current,
    output logic [7:0]       o_phase_ctrl,
    output logic [7:0]       o_pump_div,
    output logic [7:0]       o_backlash,
    output logic [7:0]       o_osc_ctrl,
    output logic [7:0]       o_osc_level,
    output logic [7:0]       o_osc_band,
    output logic [15:0]      o_fb_div,
    output logic             o_soft_reset,
    output logic             o_vco_cal
);
    ctr_pkg::ctr_pins_t  pins;        // synchronised pins
    logic                sclk_d;      // previous sclk
    logic                rise;        // sclk rising edge
    logic                fall;        // sclk falling edge
    ctr_pkg::ctr_state_t state;       // port state
    logic [15:0]         shreg;       // input shifter
    logic [4:0]          bitcnt;      // bits in current unit
    ctr_pkg::ctr_instr_t ins;         // latched instruction
    logic [12:0]         addr;        // current byte address
    logic [2:0]          bytes_left;  // bytes still due
    logic [7:0]          rd_byte;     // outgoing byte
    logic [7:0]          buf_r [`CTR_NUM_REGS];  // buffered
    logic [7:0]          act_r [`CTR_NUM_REGS];  // active
    logic                wr_stb;      // byte written this cycle
    logic [7:0]          wr_data;     // byte being written
    logic [3:0]          cal_cnt;     // autoclear task timer
    logic                trig_req;    // transfer trigger pending
    logic [7:0]          next_rd;     // read mux

    ctr_sync u_sync (
        .i_mclk (i_mclk),
        .i_rst_n(i_rst_n),
        .i_pins ({i_sclk, i_cs_n, i_sdio}),
        .o_pins (pins)
    );

    // edge detect on synchronised sclk
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= pins.sclk;
        end
    end
    assign rise = pins.sclk & ~sclk_d & ~pins.cs_n;
    assign fall = ~pins.sclk & sclk_d & ~pins.cs_n;
    assign wr_data = {shreg[6:0], pins.sdio};

    // serial state machine and shifter
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state      <= ctr_pkg::CTR_IDLE;
            shreg      <= 16'h0000;
            bitcnt     <= 5'h00;
            ins        <= 16'h0000;
            addr       <= 13'h0000;
            bytes_left <= 3'h0;
        end else if (pins.cs_n) begin
            // stall keeps context only between bytes of a counted transfer;
            // a stream ends here and a cut byte flushes
            if (bitcnt != 5'h00 || bytes_left == 3'h0 || state != ctr_pkg::CTR_DATA
                || ins.len == `CTR_LEN_STREAM) begin
                state  <= ctr_pkg::CTR_IDLE;
                bitcnt <= 5'h00;
            end
        end else if (rise) begin
            shreg <= {shreg[14:0], pins.sdio};
            unique case (state)
                ctr_pkg::CTR_IDLE: begin
                    state  <= ctr_pkg::CTR_INSTR;
                    bitcnt <= 5'h01;
                end
                ctr_pkg::CTR_INSTR: begin
                    if (bitcnt == `CTR_INS_BITS - 5'h01) begin
                        ins        <= {shreg[14:0], pins.sdio};
                        addr       <= {shreg[11:0], pins.sdio};
                        bytes_left <= shreg[13:12] == `CTR_LEN_STREAM ? 3'h4
                                                                       : {1'b0, shreg[13:12]} + 3'h1;
                        state      <= ctr_pkg::CTR_DATA;
                        bitcnt     <= 5'h00;
                    end else begin
                        bitcnt <= bitcnt + 5'h01;
                    end
                end
                ctr_pkg::CTR_DATA: begin
                    if (bitcnt == 5'h07) begin
                        bitcnt <= 5'h00;
                        addr   <= addr - 13'h0001;
                        if (ins.len != `CTR_LEN_STREAM) begin
                            bytes_left <= bytes_left - 3'h1;
                            if (bytes_left == 3'h1) begin
                                state <= ctr_pkg::CTR_IDLE;
                            end
                        end
                    end else begin
                        bitcnt <= bitcnt + 5'h01;
                    end
                end
            endcase
        end
    end
    assign wr_stb = rise && !pins.cs_n && state == ctr_pkg::CTR_DATA && bitcnt == 5'h07 && !ins.rd;

    always_comb begin
        next_rd = 8'h00;
        if (addr <= `CTR_ADDR_LAST) begin
            // select bit lives in the readback register and acts at once
            next_rd = buf_r[4][`CTR_BIT_RBSEL] ? buf_r[addr[4:0]] : act_r[addr[4:0]];
            if (addr == `CTR_ADDR_RBS || addr == `CTR_ADDR_TRIG) begin
                next_rd = buf_r[addr[4:0]];
            end
        end
    end

    // read output shifter and enable
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_byte   <= 8'h00;
            o_sdio    <= 1'b0;
            o_sdio_oe <= 1'b0;
        end else if (pins.cs_n || state != ctr_pkg::CTR_DATA || !ins.rd) begin
            o_sdio_oe <= 1'b0;
            rd_byte   <= next_rd;
        end else if (fall) begin
            o_sdio_oe <= 1'b1;
            o_sdio    <= bitcnt == 5'h00 ? next_rd[7] : rd_byte[3'h7 - bitcnt[2:0]];
            if (bitcnt == 5'h00) begin
                rd_byte <= next_rd;
            end
        end
    end

    // buffered registers, written from the port
    genvar gi;
    generate
        for (gi = 0; gi < `CTR_NUM_REGS; gi++) begin : g_reg
            localparam logic [7:0] RST = gi == 0 ? `CTR_RST_SPC : gi == 10 ? `CTR_RST_CPC :
                                         gi == 11 ? `CTR_RST_PDC : gi == 14 ? `CTR_RST_OSC :
                                         gi == 15 ? `CTR_RST_OSL : gi == 16 ? `CTR_RST_OSB :
                                         gi == 18 ? `CTR_RST_FBH : `CTR_RST_ZERO;
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    buf_r[gi] <= RST;
                end else if (wr_stb && addr == 13'(gi)) begin
                    buf_r[gi] <= wr_data;
                end else if (gi == 5 && trig_req) begin
                    buf_r[gi] <= `CTR_RST_ZERO;
                end else if (gi == 0 && buf_r[gi][`CTR_BIT_SOFTRST] && cal_cnt == 4'h1) begin
                    buf_r[gi][`CTR_BIT_SOFTRST] <= 1'b0;
                end else if (gi == 14 && buf_r[gi][`CTR_BIT_VCOCAL] && cal_cnt == 4'h1) begin
                    buf_r[gi][`CTR_BIT_VCOCAL] <= 1'b0;
                end
            end
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    act_r[gi] <= RST;
                end else if (trig_req) begin
                    act_r[gi] <= buf_r[gi];
                end else if (gi == 0 && cal_cnt == 4'h1) begin
                    // only the command bit clears, here and in the buffered copy, other bits stay put
                    act_r[gi][`CTR_BIT_SOFTRST] <= 1'b0;
                end else if (gi == 14 && cal_cnt == 4'h1) begin
                    // calibrate bit clears, other oscillator bits kept
                    act_r[gi][`CTR_BIT_VCOCAL] <= 1'b0;
                end
            end
        end
    endgenerate
    assign trig_req = buf_r[5][`CTR_BIT_TRIG];

    // task timer for autoclear commands
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cal_cnt <= 4'h0;
        end else if (trig_req && (buf_r[0][`CTR_BIT_SOFTRST] || buf_r[14][`CTR_BIT_VCOCAL])) begin
            cal_cnt <= `CTR_CAL_CYCLES;
        end else if (cal_cnt != 4'h0) begin
            cal_cnt <= cal_cnt - 4'h1;
        end
    end

    // registered active outputs
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pump_current <= `CTR_RST_CPC;
            o_phase_ctrl   <= `CTR_RST_PDC;
            o_pump_div     <= `CTR_RST_ZERO;
            o_backlash     <= `CTR_RST_ZERO;
            o_osc_ctrl     <= `CTR_RST_OSC;
            o_osc_level    <= `CTR_RST_OSL;
            o_osc_band     <= `CTR_RST_OSB;
            o_fb_div       <= {`CTR_RST_FBH, `CTR_RST_ZERO};
            o_soft_reset   <= 1'b0;
            o_vco_cal      <= 1'b0;
        end else begin
            o_pump_current <= act_r[10];
            o_phase_ctrl   <= act_r[11];
            o_pump_div     <= act_r[12];
            o_backlash     <= act_r[13];
            o_osc_ctrl     <= act_r[14];
            o_osc_level    <= act_r[15];
            o_osc_band     <= act_r[16];
            o_fb_div       <= {act_r[18], act_r[19]};
            o_soft_reset   <= act_r[0][`CTR_BIT_SOFTRST];
            o_vco_cal      <= act_r[14][`CTR_BIT_VCOCAL];
        end
    end

    // checks
    property p_trig_clears;
        @(posedge i_mclk) disable iff (!i_rst_n) trig_req |=> !trig_req;
    endproperty
    a_trig_clears: assert property (p_trig_clears) else $error("trigger not cleared");
    property p_pump_copy;
        @(posedge i_mclk) disable iff (!i_rst_n) trig_req |-> ##2 o_pump_current == $past(buf_r[10], 2);
    endproperty
    a_pump_copy: assert property (p_pump_copy) else $error("pump code not applied");
    property p_oe_quiet;
        @(posedge i_mclk) disable iff (!i_rst_n) pins.cs_n |=> !o_sdio_oe;
    endproperty
    a_oe_quiet: assert property (p_oe_quiet) else $error("sdio driven while deselected");
    property p_oe_on_fall;
        @(posedge i_mclk) disable iff (!i_rst_n) $rose(o_sdio_oe) |-> $past(fall);
    endproperty
    a_oe_on_fall: assert property (p_oe_on_fall) else $error("drive not after falling edge");
    property p_addr_dec;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (rise && state == ctr_pkg::CTR_DATA && bitcnt == 5'h07) |=> addr == $past(addr) - 13'h0001;
    endproperty
    a_addr_dec: assert property (p_addr_dec) else $error("address not decremented");
    property p_instr_len;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (state == ctr_pkg::CTR_INSTR && $past(state) == ctr_pkg::CTR_INSTR) |-> bitcnt < 5'h10;
    endproperty
    a_instr_len: assert property (p_instr_len) else $error("instruction too long");
    property p_write_buf;
        @(posedge i_mclk) disable iff (!i_rst_n) (wr_stb && addr == `CTR_ADDR_CPC) |=> buf_r[10] == $past(wr_data);
    endproperty
    a_write_buf: assert property (p_write_buf) else $error("write not stored");
    property p_act_hold;
        @(posedge i_mclk) disable iff (!i_rst_n) (!trig_req && cal_cnt == 4'h0) |=> act_r[10] == $past(act_r[10]);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("active changed without trigger");
    property p_stream_end;
        @(posedge i_mclk) disable iff (!i_rst_n)
            (pins.cs_n && state == ctr_pkg::CTR_DATA && ins.len == `CTR_LEN_STREAM) |=> state == ctr_pkg::CTR_IDLE;
    endproperty
    a_stream_end: assert property (p_stream_end) else $error("stream not ended by deselect");
    c_trig: cover property (@(posedge i_mclk) trig_req);
    c_read: cover property (@(posedge i_mclk) o_sdio_oe);
    c_write: cover property (@(posedge i_mclk) wr_stb);
endmodule
`default_nettype wire

// File: dv/ctr_host.sv
`timescale 1ns/1ns
`default_nettype none
// host model driving the three-wire control port
module ctr_host (
    // clock
    input  wire logic i_mclk,
    // device side of the data pin
    input  wire logic i_sdio_d,
    input  wire logic i_sdio_oe,
    // pins to the device
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdio
);
    logic drv; // host drives the data pin
    logic hd;  // host data bit
    logic pat; // filler while nobody drives
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        drv    = 1'b0;
        hd     = 1'b0;
        pat    = 1'b0;
    end
    // a free line toggles so a stale bit never passes
    always @(negedge i_mclk) pat <= ~pat;
    // resolved level of the shared data pin
    assign o_sdio = i_sdio_oe ? i_sdio_d : (drv ? hd : pat);
    task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                        input int nbits, input logic [31:0] wd, output logic [31:0] rq);
        logic [47:0] sh;
        sh = {rd, len, addr, wd};
        rq = 32'h0;
        @(negedge i_mclk) o_cs_n <= 1'b0;
        for (int i = 0; i < 16 + nbits; i++) begin
            @(negedge i_mclk);
            o_sclk <= 1'b0;
            // data set up while the clock is low
            drv <= !(rd && i >= 16);
            hd  <= sh[47 - i];
            repeat (10) @(negedge i_mclk);
            // read bit sampled well after the fall
            rq = {rq[30:0], o_sdio};
            o_sclk <= 1'b1;
            repeat (9) @(negedge i_mclk);
        end
        repeat (10) @(negedge i_mclk);
        o_cs_n <= 1'b1;
        drv    <= 1'b0;
        repeat (10) @(negedge i_mclk);
        // clock rests low between frames
        o_sclk <= 1'b0;
        repeat (10) @(negedge i_mclk);
    endtask
endmodule
`default_nettype wire

// File: dv/ctr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctr_map.svh"
// bench for the control register bank
module ctr_regs_tb;
    logic        mclk;       // system clock
    logic        rst_n;      // async reset
    logic        sclk;       // serial clock
    logic        cs_n;       // chip select
    logic        sdio;       // resolved data pin
    logic        sdo;        // device data out
    logic        sdo_oe;     // device drive enable
    logic [7:0]  pump;       // active outputs
    logic [7:0]  phase;
    logic [7:0]  pdiv;
    logic [7:0]  blash;
    logic [7:0]  oscc;
    logic [7:0]  oscl;
    logic [7:0]  oscb;
    logic [15:0] fbdiv;
    logic        srst;
    logic        vcal;
    logic        cal_seen;   // calibrate pulse observed
    logic [31:0] rq;         // read result
    int          errors;
    int          num_checks;
    // design under test
    ctr_regs DUT (.i_mclk(mclk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sdio(sdio), .o_sdio(sdo), .o_sdio_oe(sdo_oe), .o_pump_current(pump),
        .o_phase_ctrl(phase), .o_pump_div(pdiv), .o_backlash(blash), .o_osc_ctrl(oscc),
        .o_osc_level(oscl), .o_osc_band(oscb), .o_fb_div(fbdiv), .o_soft_reset(srst),
        .o_vco_cal(vcal));
    // host at the far side
    ctr_host host (.i_mclk(mclk), .i_sdio_d(sdo), .i_sdio_oe(sdo_oe), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdio(sdio));
    // clock
    always #4 mclk = ~mclk;
    // catch the short calibrate and soft reset pulses together
    always @(posedge mclk) if (vcal === 1'b1 && srst === 1'b1) cal_seen <= 1'b1;
    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // write nb bytes from the low nb bytes of d, first byte the highest of them
    task automatic wr(input logic [1:0] len, input logic [12:0] a, input int nb, input logic [31:0] d);
        host.xfer(1'b0, len, a, nb * 8, d << (32 - nb * 8), rq);
    endtask
    // read nb bytes, last byte in the low bits
    task automatic rd(input logic [1:0] len, input logic [12:0] a, input int nb);
        host.xfer(1'b1, len, a, nb * 8, 32'h0, rq);
    endtask
    // set the transfer trigger
    task automatic upd;
        wr(2'h0, `CTR_ADDR_TRIG, 1, 32'h01);
        repeat (10) @(negedge mclk);
    endtask
    // verdict
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (80000) @(posedge mclk);
        errors++;
        end_of_test();
    end
    // tests
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        cal_seen = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
        check("outs", {pump, phase, pdiv, blash}, 32'h80300000);
        check("osc", {oscc, oscl, oscb}, 32'h708080);
        check("fb", {fbdiv, srst, vcal}, 32'h20000);
        rd(2'h0, `CTR_ADDR_SPC, 1);
        check("spc", rq[7:0], 8'h18);
        check("oe_idle", sdo_oe, 1'b0);
        $display("test reset done");
        // buffered write, readback select, trigger
        wr(2'h0, `CTR_ADDR_CPC, 1, 32'h5A);
        check("pump_hold", pump, 8'h80);
        rd(2'h0, `CTR_ADDR_CPC, 1);
        check("rd_active", rq[7:0], 8'h80);
        wr(2'h0, `CTR_ADDR_RBS, 1, 32'h01);
        rd(2'h0, `CTR_ADDR_CPC, 1);
        check("rd_buf", rq[7:0], 8'h5A);
        upd();
        check("pump", pump, 8'h5A);
        rd(2'h0, `CTR_ADDR_TRIG, 1);
        check("trig_clr", rq[7:0], 8'h00);
        $display("test buffer done");
        // length codes 1 to 3, address walking down
        wr(2'h1, `CTR_ADDR_FBM, 2, 32'h3412);
        wr(2'h2, `CTR_ADDR_PCD, 3, 32'h05A43C);
        wr(2'h3, `CTR_ADDR_OSB, 4, 32'h9A6C7081);
        check("early", fbdiv, 16'h8000);
        upd();
        check("outs2", {pump, phase, pdiv, blash}, 32'h3CA40581);
        check("osc2", {oscc, oscl, oscb}, 32'h706C9A);
        check("fb2", fbdiv, 16'h1234);
        rd(2'h3, `CTR_ADDR_FBM, 4);
        check("stream", rq, 32'h3412009A);
        rd(2'h2, `CTR_ADDR_PCD, 3);
        check("three", rq[23:0], 24'h05A43C);
        $display("test lengths done");
        // calibrate and soft reset commands clear themselves
        cal_seen = 1'b0;
        wr(2'h0, `CTR_ADDR_SPC, 1, 32'h38);
        wr(2'h0, `CTR_ADDR_OSC, 1, 32'hF0);
        upd();
        repeat (40) @(negedge mclk);
        check("cal_seen", cal_seen, 1'b1);
        check("cal_clr", {srst, vcal, oscc}, 10'h070);
        rd(2'h0, `CTR_ADDR_SPC, 1);
        check("srst_clr", rq[7:0], 8'h18);
        $display("test autoclear done");
        // unmapped place and a frame cut mid-byte
        wr(2'h0, 13'h0020, 1, 32'hFF);
        rd(2'h0, 13'h0020, 1);
        check("unmapped", rq[7:0], 8'h00);
        host.xfer(1'b0, 2'h0, `CTR_ADDR_PDC, 4, 32'hF0000000, rq);
        rd(2'h0, `CTR_ADDR_PDC, 1);
        check("flush", rq[7:0], 8'hA4);
        $display("test refusals done");
        end_of_test();
    end
endmodule
`default_nettype wire
